// ===== core/literal_move_indirect_exec.sv
// executor for literal loads, working-register moves, indirect stores, idle and software reset
// assumes: one instruction per INSTR_VALID_I cycle from same-clock logic; plain register port
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`include "lmi_defs.svh"

module literal_move_indirect_exec #(
    parameter int MEM_AW = 8
) (
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input wire logic [13:0] INSTR_I,
    input wire logic INSTR_VALID_I,
    input wire logic [7:0] BUS_ADDR_I,
    input wire logic [7:0] BUS_WDATA_I,
    input wire logic BUS_WR_I,
    input wire logic BUS_RD_I,
    output logic [7:0] BUS_RDATA_O,
    output logic [7:0] WORK_O,
    output logic [4:0] BANK_O,
    output logic [6:0] PC_LATCH_O,
    output logic [7:0] OPTION_O,
    output logic PC_ADVANCE_O,
    output logic SOFT_RESET_O
);

    // decode of one instruction word
    function automatic lmi_pkg::dec_t decode(input logic [13:0] w);
        lmi_pkg::dec_t d;
        d.k8 = w[`LMI_K8_MSB:0];
        d.f = w[`LMI_K7_MSB:0];
        d.mode = w[`LMI_MODE_MSB:0];
        d.off = w[`LMI_K6_MSB:0];
        d.sel = w[`LMI_SEL_BIT];
        if (w == `LMI_IDLE_VAL) begin
            d.op = lmi_pkg::OP_IDLE;
        end else if (w == `LMI_SWRESET_VAL) begin
            d.op = lmi_pkg::OP_SWRESET;
        end else if (w == `LMI_OPTION_VAL) begin
            d.op = lmi_pkg::OP_OPTION;
        end else if ((w & `LMI_STW_MASK) == `LMI_STW_VAL) begin
            d.op = lmi_pkg::OP_STORE_W;
        end else if ((w & `LMI_LBANK_MASK) == `LMI_LBANK_VAL) begin
            d.op = lmi_pkg::OP_LOAD_BANK;
        end else if ((w & `LMI_LPCL_MASK) == `LMI_LPCL_VAL) begin
            d.op = lmi_pkg::OP_LOAD_PCL;
        end else if ((w & `LMI_LW_MASK) == `LMI_LW_VAL) begin
            d.op = lmi_pkg::OP_LOAD_W;
        end else if ((w & `LMI_INDM_MASK) == `LMI_INDM_VAL) begin
            d.op = lmi_pkg::OP_IND_MODE;
        end else if ((w & `LMI_INDK_MASK) == `LMI_INDK_VAL) begin
            d.op = lmi_pkg::OP_IND_OFFSET;
            d.sel = w[`LMI_KSEL_BIT];
        end else begin
            d.op = lmi_pkg::OP_OTHER;
        end
        return d;
    endfunction

    // memory index from a 16-bit address, wrapping into the array
    function automatic logic [MEM_AW-1:0] mem_idx(input logic [15:0] a);
        return a[MEM_AW-1:0];
    endfunction

    logic [7:0] work_r;
    logic [4:0] bank_r;
    logic [6:0] pcl_r;
    logic [7:0] opt_r;
    logic [15:0] ptr0_r;
    logic [15:0] ptr1_r;
    logic rst_flag_n_r;
    logic [2:0] stat_r;
    logic [15:0] maddr_r;
    logic [7:0] rdata_r;
    logic adv_r;
    logic swr_r;
    logic [7:0] mem [0:(1<<MEM_AW)-1];

    lmi_pkg::dec_t dec;
    lmi_pkg::bus_req_t req;
    wire ex = INSTR_VALID_I;

    assign dec = decode(INSTR_I);
    assign req = '{addr: BUS_ADDR_I, wdata: BUS_WDATA_I, wr: BUS_WR_I, rd: BUS_RD_I};

    wire is_ind = ex && (dec.op == lmi_pkg::OP_IND_MODE || dec.op == lmi_pkg::OP_IND_OFFSET);
    wire is_stw = ex && dec.op == lmi_pkg::OP_STORE_W;
    wire is_swr = ex && dec.op == lmi_pkg::OP_SWRESET;
    wire [15:0] sel_ptr = dec.sel ? ptr1_r : ptr0_r;
    wire [15:0] ptr_inc = sel_ptr + 16'h0001;
    wire [15:0] ptr_dec = sel_ptr - 16'h0001;
    wire [15:0] off_ext = {{10{dec.off[5]}}, dec.off};
    wire [15:0] ptr_off = sel_ptr + off_ext;

    // effective address per mode code
    logic [15:0] ind_ea;
    logic [15:0] ptr_new;
    always_comb begin
        ind_ea = sel_ptr;
        ptr_new = sel_ptr;
        if (dec.op == lmi_pkg::OP_IND_OFFSET) begin
            ind_ea = ptr_off;
            ptr_new = sel_ptr;
        end else begin
            unique case (dec.mode)
                2'b00: begin
                    ind_ea = ptr_inc;
                    ptr_new = ptr_inc;
                end
                2'b01: begin
                    ind_ea = ptr_dec;
                    ptr_new = ptr_dec;
                end
                2'b10: begin
                    ind_ea = sel_ptr;
                    ptr_new = ptr_inc;
                end
                2'b11: begin
                    ind_ea = sel_ptr;
                    ptr_new = ptr_dec;
                end
            endcase
        end
    end

    // direct store: window addresses go through the pointers
    wire stw_win0 = dec.f == `LMI_F_WIN0;
    wire stw_win1 = dec.f == `LMI_F_WIN1;
    wire [15:0] stw_ea = stw_win0 ? ptr0_r : stw_win1 ? ptr1_r : {4'h0, bank_r[3:0], 1'b0, dec.f};

    // bus decode
    wire bw_work = req.wr && req.addr == `LMI_A_WORK;
    wire bw_bank = req.wr && req.addr == `LMI_A_BANK;
    wire bw_pcl = req.wr && req.addr == `LMI_A_PCL;
    wire bw_opt = req.wr && req.addr == `LMI_A_OPT;
    wire bw_ptr0 = req.wr && req.addr == `LMI_A_PTR0;
    wire bw_ptr1 = req.wr && req.addr == `LMI_A_PTR1;
    wire bw_power_control_reg = req.wr && req.addr == `LMI_A_POWER_CONTROL_REG;
    wire bw_stat = req.wr && req.addr == `LMI_A_STAT;
    wire bw_maddr = req.wr && req.addr == `LMI_A_MADDR;
    wire bw_mdata = req.wr && req.addr == `LMI_A_MDATA;
    wire bw_win0 = req.wr && req.addr == `LMI_A_WIN0;
    wire bw_win1 = req.wr && req.addr == `LMI_A_WIN1;

    // memory write port: instruction first, bus second
    wire mem_we = is_ind || is_stw || bw_mdata || bw_win0 || bw_win1;
    wire [15:0] bus_ma = bw_win0 ? ptr0_r : bw_win1 ? ptr1_r : maddr_r;
    wire [15:0] mem_wa = is_ind ? ind_ea : is_stw ? stw_ea : bus_ma;
    wire [7:0] mem_wd = (is_ind || is_stw) ? work_r : req.wdata;

    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        unique case (req.addr)
            `LMI_A_WORK: rd_val = work_r;
            `LMI_A_BANK: rd_val = {3'h0, bank_r};
            `LMI_A_PCL: rd_val = {1'b0, pcl_r};
            `LMI_A_OPT: rd_val = opt_r;
            `LMI_A_PTR0: rd_val = ptr0_r[7:0];
            `LMI_A_PTR1: rd_val = ptr1_r[7:0];
            `LMI_A_POWER_CONTROL_REG: rd_val = {7'h00, rst_flag_n_r};
            `LMI_A_STAT: rd_val = {5'h00, stat_r};
            `LMI_A_MADDR: rd_val = maddr_r[7:0];
            `LMI_A_MDATA: rd_val = mem[mem_idx(maddr_r)];
            `LMI_A_WIN0: rd_val = mem[mem_idx(ptr0_r)];
            `LMI_A_WIN1: rd_val = mem[mem_idx(ptr1_r)];
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (mem_we) begin
            mem[mem_idx(mem_wa)] <= mem_wd;
        end
    end

    // core state; a software reset restores all but the memory and the reset flag
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I || is_swr) begin
            work_r <= `LMI_RST_WORK;
            bank_r <= `LMI_RST_BANK;
            pcl_r <= `LMI_RST_PCL;
            opt_r <= `LMI_RST_OPT;
            ptr0_r <= `LMI_RST_PTR;
            ptr1_r <= `LMI_RST_PTR;
            stat_r <= `LMI_RST_STAT;
            maddr_r <= `LMI_RST_MADDR;
        end else begin
            if (ex && dec.op == lmi_pkg::OP_LOAD_W) begin
                work_r <= dec.k8;
            end else if (bw_work) begin
                work_r <= req.wdata;
            end
            if (ex && dec.op == lmi_pkg::OP_LOAD_BANK) begin
                bank_r <= dec.k8[`LMI_K5_MSB:0];
            end else if (bw_bank) begin
                bank_r <= req.wdata[4:0];
            end
            if (ex && dec.op == lmi_pkg::OP_LOAD_PCL) begin
                pcl_r <= dec.f;
            end else if (bw_pcl) begin
                pcl_r <= req.wdata[6:0];
            end
            if (ex && dec.op == lmi_pkg::OP_OPTION) begin
                opt_r <= work_r;
            end else if (bw_opt) begin
                opt_r <= req.wdata;
            end
            if (is_ind && !dec.sel) begin
                ptr0_r <= ptr_new;
            end else if (bw_ptr0) begin
                ptr0_r <= {8'h00, req.wdata};
            end
            if (is_ind && dec.sel) begin
                ptr1_r <= ptr_new;
            end else if (bw_ptr1) begin
                ptr1_r <= {8'h00, req.wdata};
            end
            // no instruction here touches status
            if (bw_stat) begin
                stat_r <= req.wdata[2:0];
            end
            if (bw_maddr) begin
                maddr_r <= {8'h00, req.wdata};
            end
        end
    end

    // reset flag: power-on sets, software reset clears, clear wins over bus set
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            rst_flag_n_r <= 1'b1;
        end else if (is_swr) begin
            rst_flag_n_r <= 1'b0;
        end else if (bw_power_control_reg) begin
            rst_flag_n_r <= req.wdata[0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            rdata_r <= 8'h00;
            adv_r <= 1'b0;
            swr_r <= 1'b0;
        end else begin
            rdata_r <= req.rd ? rd_val : 8'h00;
            adv_r <= ex && !is_swr;
            swr_r <= is_swr;
        end
    end

    assign BUS_RDATA_O = rdata_r;
    assign WORK_O = work_r;
    assign BANK_O = bank_r;
    assign PC_LATCH_O = pcl_r;
    assign OPTION_O = opt_r;
    assign PC_ADVANCE_O = adv_r;
    assign SOFT_RESET_O = swr_r;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);

    logic [7:0] work_q;
    lmi_pkg::dec_t dec_q;
    logic ex_q;
    always_ff @(posedge SYS_CLK_I) begin
        work_q <= work_r;
        dec_q <= dec;
        ex_q <= ex;
    end

    sequence idle_exec_s;
        ex && dec.op == lmi_pkg::OP_IDLE && !req.wr;
    endsequence

    sequence ind0_exec_s;
        is_ind && !dec.sel && !bw_ptr0;
    endsequence

    bank_load_a: assert property (ex && dec.op == lmi_pkg::OP_LOAD_BANK |=>
        BANK_O == $past(dec.k8[4:0]) && stat_r == $past(stat_r))
        else $error("bank select not loaded");
    pcl_load_a: assert property (ex && dec.op == lmi_pkg::OP_LOAD_PCL |=> PC_LATCH_O == $past(dec.f))
        else $error("pc latch not loaded");
    work_load_a: assert property (ex && dec.op == lmi_pkg::OP_LOAD_W |=> WORK_O == $past(dec.k8) && PC_ADVANCE_O)
        else $error("working register not loaded");
    store_w_a: assert property (ex_q && dec_q.op == lmi_pkg::OP_STORE_W && dec_q.f > 7'h01
        |-> mem[mem_idx({4'h0, $past(bank_r[3:0]), 1'b0, dec_q.f})] == work_q)
        else $error("file store lost");
    ind_addr_a: assert property (is_ind && dec.op == lmi_pkg::OP_IND_MODE && dec.mode == 2'b00
        |-> mem_wa == sel_ptr + 16'h0001 && mem_wd == work_r)
        else $error("preincrement address wrong");
    ind_mode_a: assert property (is_ind && dec.op == lmi_pkg::OP_IND_MODE && dec.mode == 2'b11
        |-> mem_wa == sel_ptr)
        else $error("postdecrement address wrong");
    ptr_update_a: assert property (ind0_exec_s ##0 (dec.op == lmi_pkg::OP_IND_OFFSET) |=>
        ptr0_r == $past(ptr0_r))
        else $error("offset form moved pointer");
    ptr_wrap_a: assert property (ind0_exec_s ##0 (dec.op == lmi_pkg::OP_IND_MODE && dec.mode == 2'b00
        && ptr0_r == 16'hffff) |=> ptr0_r == 16'h0000)
        else $error("pointer did not wrap");
    stat_keep_a: assert property (is_ind && !bw_stat |=> $stable(stat_r))
        else $error("status touched by pointer update");
    opt_load_a: assert property (ex && dec.op == lmi_pkg::OP_OPTION |=> OPTION_O == $past(work_r))
        else $error("option not loaded");
    soft_reset_a: assert property (is_swr |=> !rst_flag_n_r && SOFT_RESET_O && WORK_O == `LMI_RST_WORK
        ##1 !SOFT_RESET_O)
        else $error("software reset incomplete");
    idle_keep_a: assert property (idle_exec_s |=> PC_ADVANCE_O && $stable(work_r) && $stable(ptr0_r)
        && $stable(bank_r))
        else $error("idle changed state");

    sequence ind_mode_exec_s;
        is_ind && dec.op == lmi_pkg::OP_IND_MODE;
    endsequence

    ind_predec_a: assert property (ind_mode_exec_s ##0 (dec.mode == 2'b01)
        |-> mem_wa == sel_ptr - 16'h0001)
        else $error("predecrement address wrong");
    ind_postinc_a: assert property (ind_mode_exec_s ##0 (dec.mode == 2'b10)
        |-> mem_wa == sel_ptr)
        else $error("postincrement address wrong");
    ind_offset_a: assert property (is_ind && dec.op == lmi_pkg::OP_IND_OFFSET
        |-> mem_wa == sel_ptr + 16'(signed'(dec.off)) && mem_we && mem_wd == work_r)
        else $error("offset address wrong");
    ptr_step_a: assert property (ind0_exec_s ##0 (dec.op == lmi_pkg::OP_IND_MODE) |=>
        ptr0_r == ($past(dec.mode[0]) ? $past(ptr0_r) - 16'h0001 : $past(ptr0_r) + 16'h0001))
        else $error("pointer step wrong");
    win_store_a: assert property (is_stw && dec.f == `LMI_F_WIN1
        |-> mem_wa == ptr1_r && mem_wd == work_r)
        else $error("window store missed pointer");
    adv_pulse_a: assert property (!ex |=> !PC_ADVANCE_O)
        else $error("advance pulse too long");
    opt_flags_a: assert property (ex && dec.op == lmi_pkg::OP_OPTION && !bw_stat |=> $stable(stat_r))
        else $error("option load touched status");

endmodule // literal_move_indirect_exec

// ===== core/lmi_defs.svh
// offsets, encodings, field positions and reset values for the move/literal executor
// assumes: 14-bit instruction words, byte-wide data path
`ifndef LMI_DEFS_SVH
`define LMI_DEFS_SVH

// instruction match masks and values
`define LMI_IDLE_VAL 14'h0000
`define LMI_SWRESET_VAL 14'h0001
`define LMI_OPTION_VAL 14'h0062
`define LMI_STW_MASK 14'h3f80
`define LMI_STW_VAL 14'h0080
`define LMI_LBANK_MASK 14'h3fe0
`define LMI_LBANK_VAL 14'h0020
`define LMI_LPCL_MASK 14'h3f80
`define LMI_LPCL_VAL 14'h3180
`define LMI_LW_MASK 14'h3f00
`define LMI_LW_VAL 14'h3000
`define LMI_INDM_MASK 14'h3ff8
`define LMI_INDM_VAL 14'h0018
`define LMI_INDK_MASK 14'h3f80
`define LMI_INDK_VAL 14'h3f80

// operand field positions
`define LMI_K8_MSB 7
`define LMI_K7_MSB 6
`define LMI_K5_MSB 4
`define LMI_K6_MSB 5
`define LMI_SEL_BIT 2
`define LMI_MODE_MSB 1
`define LMI_KSEL_BIT 6

// file addresses that alias the indirect windows
`define LMI_F_WIN0 7'h00
`define LMI_F_WIN1 7'h01

// register bus offsets
`define LMI_A_WORK 8'h00
`define LMI_A_BANK 8'h04
`define LMI_A_PCL 8'h08
`define LMI_A_OPT 8'h0c
`define LMI_A_PTR0 8'h10
`define LMI_A_PTR1 8'h14
`define LMI_A_POWER_CONTROL_REG 8'h18
`define LMI_A_STAT 8'h1c
`define LMI_A_MADDR 8'h20
`define LMI_A_MDATA 8'h24
`define LMI_A_WIN0 8'h28
`define LMI_A_WIN1 8'h2c

// reset values
`define LMI_RST_WORK 8'h00
`define LMI_RST_BANK 5'h00
`define LMI_RST_PCL 7'h00
`define LMI_RST_OPT 8'hff
`define LMI_RST_PTR 16'h0000
`define LMI_RST_STAT 3'h0
`define LMI_RST_MADDR 16'h0000

`endif

// ===== core/lmi_pkg.sv
// types for the move/literal executor
// assumes: constants come from lmi_defs.svh
package lmi_pkg;

    typedef enum logic [3:0] {
        OP_IDLE = 4'b0000,
        OP_SWRESET = 4'b0001,
        OP_OPTION = 4'b0010,
        OP_STORE_W = 4'b0011,
        OP_LOAD_BANK = 4'b0100,
        OP_LOAD_PCL = 4'b0101,
        OP_LOAD_W = 4'b0110,
        OP_IND_MODE = 4'b0111,
        OP_IND_OFFSET = 4'b1000,
        OP_OTHER = 4'b1001
    } op_t;

    typedef struct packed {
        op_t op;
        logic [7:0] k8;
        logic [6:0] f;
        logic sel;
        logic [1:0] mode;
        logic [5:0] off;
    } dec_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// ===== test/tb_literal_move_indirect_exec.sv
// self-checking bench for the move/literal executor: literals, stores, indirect modes, idle, reset
// assumes: design files under core/, register port read data stands in the cycle after the strobe
`timescale 1ns/1ps
`include "lmi_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, (ex), (got)); end end

module tb_literal_move_indirect_exec;
    logic SYS_CLK_I = 1'b0;
    logic RESETN_I = 1'b0;
    logic [13:0] INSTR_I = 14'h0000;
    logic INSTR_VALID_I = 1'b0;
    logic [7:0] BUS_ADDR_I = 8'h00;
    logic [7:0] BUS_WDATA_I = 8'h00;
    logic BUS_WR_I = 1'b0;
    logic BUS_RD_I = 1'b0;
    logic [7:0] BUS_RDATA_O;
    logic [7:0] WORK_O;
    logic [4:0] BANK_O;
    logic [6:0] PC_LATCH_O;
    logic [7:0] OPTION_O;
    logic PC_ADVANCE_O;
    logic SOFT_RESET_O;
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;

    literal_move_indirect_exec #(.MEM_AW(8)) DUT (
        .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .INSTR_I(INSTR_I), .INSTR_VALID_I(INSTR_VALID_I),
        .BUS_ADDR_I(BUS_ADDR_I), .BUS_WDATA_I(BUS_WDATA_I), .BUS_WR_I(BUS_WR_I), .BUS_RD_I(BUS_RD_I),
        .BUS_RDATA_O(BUS_RDATA_O), .WORK_O(WORK_O), .BANK_O(BANK_O), .PC_LATCH_O(PC_LATCH_O),
        .OPTION_O(OPTION_O), .PC_ADVANCE_O(PC_ADVANCE_O), .SOFT_RESET_O(SOFT_RESET_O)
    );

    always #2.5 SYS_CLK_I = ~SYS_CLK_I;

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge SYS_CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic exec(input logic [13:0] w);
        @(posedge SYS_CLK_I);
        INSTR_I <= w;
        INSTR_VALID_I <= 1'b1;
        @(posedge SYS_CLK_I);
        INSTR_VALID_I <= 1'b0;
        #1;
        `CHK("advance pulse", (w != `LMI_SWRESET_VAL), PC_ADVANCE_O)
        `CHK("soft reset pulse", (w == `LMI_SWRESET_VAL), SOFT_RESET_O)
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK_I);
        BUS_ADDR_I <= a;
        BUS_WDATA_I <= d;
        BUS_WR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        BUS_WR_I <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
        @(posedge SYS_CLK_I);
        BUS_ADDR_I <= a;
        BUS_RD_I <= 1'b1;
        @(posedge SYS_CLK_I);
        BUS_RD_I <= 1'b0;
        #1;
        `CHK(nm, ex, BUS_RDATA_O)
    endtask

    task automatic mem_chk(input logic [7:0] idx, input logic [7:0] ex);
        bus_wr(`LMI_A_MADDR, idx);
        rd_chk(`LMI_A_MDATA, ex, "memory byte");
    endtask

    function automatic logic [15:0] ea_f(input logic [15:0] p, input logic [1:0] mm);
        case (mm)
            2'b00: return p + 16'h0001;
            2'b01: return p - 16'h0001;
            default: return p;
        endcase
    endfunction

    function automatic logic [15:0] np_f(input logic [15:0] p, input logic [1:0] mm);
        return mm[0] ? p - 16'h0001 : p + 16'h0001;
    endfunction

    initial begin
        logic [7:0] w;
        logic [7:0] k;
        logic [7:0] f;
        logic [7:0] p;
        logic [7:0] pa;
        logic [5:0] k6;
        logic [15:0] e;
        void'($urandom(40));
        repeat (16) @(posedge SYS_CLK_I);
        RESETN_I <= 1'b1;
        rd_chk(`LMI_A_OPT, 8'hff, "option at reset");
        rd_chk(`LMI_A_POWER_CONTROL_REG, 8'h01, "reset flag at reset");
        rd_chk(`LMI_A_STAT, 8'h00, "status at reset");
        bus_wr(`LMI_A_STAT, 8'h05);
        for (int i = 0; i < 8; i++) begin
            k = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
            exec(`LMI_LW_VAL | {6'h00, k});
            `CHK("working", k, WORK_O)
            exec(`LMI_LBANK_VAL | {10'h000, k[3:0]});
            `CHK("bank", {1'b0, k[3:0]}, BANK_O)
            exec(`LMI_LPCL_VAL | {7'h00, k[6:0]});
            `CHK("pc latch", k[6:0], PC_LATCH_O)
        end
        rd_chk(`LMI_A_STAT, 8'h05, "status after literals");
        $display("test literals done");
        for (int i = 0; i < 4; i++) begin
            f = (i == 0) ? 8'h7f : 8'h02 + 8'($urandom() % 126);
            w = 8'($urandom());
            exec(`LMI_LBANK_VAL | {10'h000, 4'($urandom())});
            exec(`LMI_LW_VAL | {6'h00, w});
            exec(`LMI_STW_VAL | {7'h00, f[6:0]});
            mem_chk(f, w);
        end
        for (int nn = 0; nn < 2; nn++) begin
            pa = nn[0] ? `LMI_A_PTR1 : `LMI_A_PTR0;
            w = 8'($urandom());
            bus_wr(pa, 8'h40 + 8'(nn));
            exec(`LMI_LW_VAL | {6'h00, w});
            exec(`LMI_STW_VAL | {13'h0000, nn[0]});
            mem_chk(8'h40 + 8'(nn), w);
            rd_chk(nn[0] ? `LMI_A_WIN1 : `LMI_A_WIN0, w, "window read");
        end
        $display("test stores done");
        w = 8'($urandom());
        exec(`LMI_LW_VAL | {6'h00, w});
        exec(`LMI_OPTION_VAL);
        `CHK("option", w, OPTION_O)
        `CHK("working kept", w, WORK_O)
        bus_wr(`LMI_A_WORK, 8'h96);
        exec(`LMI_OPTION_VAL);
        `CHK("option from bus working", 8'h96, OPTION_O)
        $display("test option done");
        for (int nn = 0; nn < 2; nn++) begin
            pa = nn[0] ? `LMI_A_PTR1 : `LMI_A_PTR0;
            for (int m = 0; m < 4; m++) begin
                p = m[0] ? 8'h00 : 8'($urandom());
                w = 8'($urandom());
                bus_wr(pa, p);
                exec(`LMI_LW_VAL | {6'h00, w});
                exec(`LMI_INDM_VAL | {11'h000, nn[0], m[1:0]});
                e = ea_f({8'h00, p}, m[1:0]);
                mem_chk(e[7:0], w);
                e = np_f({8'h00, p}, m[1:0]);
                rd_chk(pa, e[7:0], "pointer after move");
            end
            for (int j = 0; j < 3; j++) begin
                k6 = (j == 0) ? 6'h20 : (j == 1) ? 6'h1f : 6'($urandom());
                p = (j == 0) ? 8'h10 : 8'($urandom());
                w = 8'($urandom());
                bus_wr(pa, p);
                exec(`LMI_LW_VAL | {6'h00, w});
                exec(`LMI_INDK_VAL | {7'h00, nn[0], k6});
                e = {8'h00, p} + {{10{k6[5]}}, k6};
                mem_chk(e[7:0], w);
                rd_chk(pa, p, "pointer after offset");
            end
        end
        bus_wr(`LMI_A_PTR0, 8'h00);
        exec(`LMI_INDM_VAL | 14'h0001);
        w = 8'($urandom());
        exec(`LMI_LW_VAL | {6'h00, w});
        exec(`LMI_INDM_VAL | 14'h0000);
        mem_chk(8'h00, w);
        rd_chk(`LMI_A_PTR0, 8'h00, "pointer wrapped up");
        rd_chk(`LMI_A_STAT, 8'h05, "status after indirect");
        $display("test indirect done");
        exec(`LMI_LW_VAL | 14'h003c);
        exec(`LMI_OPTION_VAL);
        exec(`LMI_LBANK_VAL | 14'h000a);
        exec(`LMI_LPCL_VAL | 14'h0055);
        bus_wr(`LMI_A_PTR0, 8'h77);
        exec(`LMI_IDLE_VAL);
        `CHK("idle working", 8'h3c, WORK_O)
        `CHK("idle bank", 5'h0a, BANK_O)
        `CHK("idle pc latch", 7'h55, PC_LATCH_O)
        `CHK("idle option", 8'h3c, OPTION_O)
        rd_chk(`LMI_A_PTR0, 8'h77, "idle pointer");
        rd_chk(`LMI_A_STAT, 8'h05, "idle status");
        exec(14'h0002);
        `CHK("undecoded working", 8'h3c, WORK_O)
        `CHK("undecoded option", 8'h3c, OPTION_O)
        `CHK("undecoded bank", 5'h0a, BANK_O)
        $display("test idle done");
        exec(`LMI_SWRESET_VAL);
        `CHK("working after soft reset", 8'h00, WORK_O)
        `CHK("bank after soft reset", 5'h00, BANK_O)
        rd_chk(`LMI_A_OPT, 8'hff, "option after soft reset");
        rd_chk(`LMI_A_PTR0, 8'h00, "pointer after soft reset");
        rd_chk(`LMI_A_POWER_CONTROL_REG, 8'h00, "reset flag after soft reset");
        $display("test soft reset done");
        exec(`LMI_LW_VAL | 14'h005a);
        @(posedge SYS_CLK_I);
        RESETN_I <= 1'b0;
        repeat (2) @(posedge SYS_CLK_I);
        RESETN_I <= 1'b1;
        #1;
        `CHK("working after hardware reset", 8'h00, WORK_O)
        rd_chk(`LMI_A_POWER_CONTROL_REG, 8'h01, "reset flag after hardware reset");
        rd_chk(`LMI_A_OPT, 8'hff, "option after hardware reset");
        $display("test hardware reset done");
        print_verdict();
    end
endmodule // tb_literal_move_indirect_exec
